// ==== pcd_pkg.sv ====
package pcd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int CHR_SETUP_L_NS  = 6400;
  localparam int CHR_SETUP_S_NS  = 4800;
  localparam int PT_SETUP_NS     = 3200;
  localparam int SETTLE_NS       = 15000;
  localparam int DARK_NS         = 1000;
  localparam int LIT_NS          = 3000;
  localparam int PT_LIT_NS       = 1000;

  localparam logic [15:0] CHR_SETUP_L_CYC =
    16'((CHR_SETUP_L_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] CHR_SETUP_S_CYC =
    16'((CHR_SETUP_S_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] PT_SETUP_CYC =
    16'((PT_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] SETTLE_CYC = 16'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] DARK_CYC   = 16'((DARK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] LIT_CYC    = 16'((LIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] PT_LIT_CYC = 16'((PT_LIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Character geometry
  // ----------------------------------------------------------------
  localparam logic [11:0] FULL_XINC  = 12'h008;
  localparam logic [11:0] HALF_XINC  = 12'h004;
  localparam logic [4:0]  FULL_ACLOW = 5'h18;
  localparam logic [3:0]  HALF_ACLOW = 4'hc;
  localparam logic [3:0]  COL_PTS    = 4'h6;
  localparam logic [3:0]  LAST_PT    = 4'hb;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_STATUS  = 4'h1;
  localparam logic [3:0]  REG_XPOS    = 4'h2;
  localparam logic [3:0]  REG_YPOS    = 4'h3;
  localparam int          CTRL_SIZE   = 0;
  localparam logic        SIZE_RESET  = 1'b1;
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_STALL  = 1;
  localparam int          STAT_PEND   = 2;

  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_SETTLE, S_DWELL} pcd_state_t;

  typedef struct packed {
    logic        is_char;
    logic        short_setup;
    logic        indirect;
    logic [11:0] ac;
    logic [11:0] idx;
    logic [11:0] pat;
    logic [11:0] xloc;
  } pcd_cmd_t;

endpackage : pcd_pkg

// ==== pcd_ctrl.sv ====
`timescale 1ns/100ps
// Contract
// [RULE1] A new display request while busy stalls the processor until the controller is free.
// [RULE2] Half-size mode, size flag clear, steps every point by two instead of four.
// [RULE3] Half-size start row comes from accumulator bits 3-7 with half-size low bits.
// [RULE4] Half-size mode advances the stored horizontal coordinate by 4, not octal 10.
// [RULE5] Half-size mode halves vertical spacing, leaving four points between text lines; the code leaves two (rows 12 and 14 of 16).
// [RULE6] Wait 15 us settling, then 1 us per dark bit, 3 us per lit bit.
// [RULE7] Scan ends when no lit points remain; outputs hold the last lit point.
// [RULE8] Point row from accumulator bits 3-11, column from index register bits 3-11.
// [RULE9] Point channel is chosen by index register bit 0.
// [RULE10] Indirect point first increments index by one in 10 bits, top two kept.
// [RULE11] Character shows a 2 by 6 array; ones lit, zeros dark.
// [RULE12] Program keeps character column in location 0001, never as index register.
// [RULE13] Full-size points are four grid positions apart both ways.
// [RULE14] First character step copies the pattern word into the intensify buffer.
// [RULE15] Accumulator bits 3-6 load the row buffer; bits 7-11 become octal 30.
// [RULE16] Stored column is increased by octal 10 and loaded into the column buffer.
// [RULE17] Processor released 4.8 or 6.4 us after setup; scan continues alone.
// [RULE18] Full-size characters start only at rows that are multiples of octal 40.
// [RULE19] Coordinate converters are loaded whole in one parallel jam transfer.
// [RULE20] Coordinates held in two 9-bit buffers, pattern in 12-bit buffer all scan.
// [RULE21] Scan column by column, bottom to top, stepping row per bit.
module pcd_ctrl
(
  input  wire logic             CLK_SYS_IN,     // System clock
  input  wire logic             RST_IN,         // Async reset, active high
  input  wire logic             REQ_VALID_IN,   // One-cycle display request
  input  wire pcd_pkg::pcd_cmd_t REQ_CMD_IN,    // Request operands
  output logic                  STALL_OUT,      // Processor must wait
  output logic                  DONE_OUT,       // Setup results valid pulse
  output logic [11:0]           AC_RES_OUT,     // Accumulator after setup
  output logic [11:0]           IDX_RES_OUT,    // Index register after setup
  output logic [11:0]           XLOC_RES_OUT,   // New character column word
  output logic [8:0]            X_OUT,          // Horizontal converter
  output logic [8:0]            Y_OUT,          // Vertical converter
  output logic                  INTENS_OUT,     // Intensify level
  output logic                  CHAN_OUT,       // Intensify channel
  output logic                  BUSY_OUT,       // Controller active
  input  wire logic [3:0]       REG_ADDR_IN,    // Register address
  input  wire logic [11:0]      REG_WDATA_IN,   // Register write data
  input  wire logic             REG_WR_IN,      // Register write strobe
  input  wire logic             REG_RD_IN,      // Register read strobe
  output logic [11:0]           REG_RDATA_OUT   // Read data, next cycle
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic bit_at(input logic [11:0] p, input logic [3:0] i);
    return p[4'd11 - i];
  endfunction : bit_at

  function automatic logic more_after(input logic [11:0] p, input logic [3:0] i);
    logic [11:0] m;
    m = 12'hfff >> (i + 4'h1);
    return (p & m) != 12'h000;
  endfunction : more_after

  // Bit order: first column bottom to top, then second column
  function automatic logic [17:0] coord(input logic [8:0] xb, input logic [8:0] yb,
                                        input logic half, input logic [3:0] i);
    logic       col;
    logic [3:0] row;
    logic [8:0] xs;
    logic [8:0] ys;
    col = (i >= pcd_pkg::COL_PTS);
    row = col ? i - pcd_pkg::COL_PTS : i;
    xs  = col ? (half ? 9'h002 : 9'h004) : 9'h000;
    ys  = half ? {4'h0, row, 1'b0} : {3'h0, row, 2'b00};
    return {xb + xs, yb + ys};                                 // see [RULE21]
  endfunction : coord

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pcd_pkg::pcd_state_t state_q;
  pcd_pkg::pcd_state_t state_d;
  pcd_pkg::pcd_cmd_t   cmd_q;
  pcd_pkg::pcd_cmd_t   pend_q;
  logic                pend_v_q;
  logic [15:0]         tmr_q;
  logic [15:0]         tmr_d;
  logic [3:0]          cnt_q;
  logic [3:0]          cnt_d;
  logic [8:0]          xb_q;
  logic [8:0]          yb_q;
  logic [11:0]         pat_q;
  logic                op_char_q;
  logic                half_q;
  logic                size_q;
  logic                lit_d;
  logic                launch;
  logic                setup_end;
  logic                dwell_go;
  logic                jam;
  logic [3:0]          dwell_idx;

  wire logic tmr_done = (tmr_q == 16'h0001);
  wire logic active   = (state_q == pcd_pkg::S_SETTLE) || (state_q == pcd_pkg::S_DWELL);
  wire logic pend_set = REQ_VALID_IN && active && !pend_v_q;           // see [RULE1]
  wire logic pend_v_d = pend_set || (pend_v_q && !launch);
  wire pcd_pkg::pcd_cmd_t src = pend_v_q ? pend_q : REQ_CMD_IN;

  // ----------------------------------------------------------------
  // Setup arithmetic
  // ----------------------------------------------------------------
  wire logic        half_w  = !size_q;                                  // see [RULE2]
  wire logic [11:0] idx_inc = {cmd_q.idx[11:10], cmd_q.idx[9:0] + 10'h001}; // see [RULE10]
  wire logic [11:0] idx_eff = cmd_q.indirect ? idx_inc : cmd_q.idx;
  wire logic [11:0] xloc_nw = cmd_q.xloc + (half_w ? pcd_pkg::HALF_XINC
                                                   : pcd_pkg::FULL_XINC); // see [RULE4] [RULE16]
  // Low row bits forced to zero so arrays start on fixed intervals
  wire logic [8:0]  yc_base = half_w ? {cmd_q.ac[8:4], 4'h0}           // see [RULE3] [RULE5]
                                     : {cmd_q.ac[8:5], 5'h00};         // see [RULE15] [RULE18]
  wire logic [11:0] ac_chr  = half_w ? {cmd_q.ac[11:4], pcd_pkg::HALF_ACLOW}
                                     : {cmd_q.ac[11:5], pcd_pkg::FULL_ACLOW}; // see [RULE15]
  wire logic [15:0] setup_cyc = !src.is_char ? pcd_pkg::PT_SETUP_CYC
                              : src.short_setup ? pcd_pkg::CHR_SETUP_S_CYC
                              : pcd_pkg::CHR_SETUP_L_CYC;
  wire logic [17:0] jam_xy  = coord(xb_q, yb_q, half_q, dwell_idx);    // see [RULE13] [RULE2]

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d   = state_q;
    tmr_d     = (tmr_q != 16'h0000) ? tmr_q - 16'h0001 : 16'h0000;
    cnt_d     = cnt_q;
    lit_d     = INTENS_OUT;
    launch    = 1'b0;
    setup_end = 1'b0;
    dwell_go  = 1'b0;
    dwell_idx = cnt_q;
    case (state_q)
      pcd_pkg::S_IDLE:
        if (pend_v_q || REQ_VALID_IN)
        begin
          launch  = 1'b1;
          state_d = pcd_pkg::S_SETUP;
          tmr_d   = setup_cyc;
        end
      pcd_pkg::S_SETUP:
        if (tmr_done)
        begin
          setup_end = 1'b1;                                     // see [RULE17]
          state_d   = pcd_pkg::S_SETTLE;
          tmr_d     = pcd_pkg::SETTLE_CYC;                       // see [RULE6]
        end
      pcd_pkg::S_SETTLE:
        if (tmr_done)
        begin
          if (op_char_q && pat_q == 12'h000)
            state_d = pcd_pkg::S_IDLE;                           // see [RULE7]
          else
          begin
            state_d   = pcd_pkg::S_DWELL;
            cnt_d     = 4'h0;
            dwell_go  = 1'b1;
            dwell_idx = 4'h0;
          end
        end
      pcd_pkg::S_DWELL:
        if (tmr_done)
        begin
          lit_d = 1'b0;
          if (!op_char_q || cnt_q == pcd_pkg::LAST_PT || !more_after(pat_q, cnt_q))
            state_d = pcd_pkg::S_IDLE;                           // see [RULE7]
          else
          begin
            cnt_d     = cnt_q + 4'h1;
            dwell_go  = 1'b1;
            dwell_idx = cnt_q + 4'h1;
          end
        end
      default:
        state_d = pcd_pkg::S_IDLE;
    endcase
    if (dwell_go)
    begin
      lit_d = !op_char_q || bit_at(pat_q, dwell_idx);            // see [RULE11]
      tmr_d = !op_char_q ? pcd_pkg::PT_LIT_CYC
            : lit_d ? pcd_pkg::LIT_CYC : pcd_pkg::DARK_CYC;      // see [RULE6]
    end
  end

  // Dark points never move the beam, so it rests on the last lit one
  assign jam = dwell_go && lit_d;                                // see [RULE7]

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      state_q  <= pcd_pkg::S_IDLE;
      tmr_q    <= 16'h0000;
      cnt_q    <= 4'h0;
      pend_v_q <= 1'b0;
      pend_q   <= '0;
      cmd_q    <= '0;
    end
    else
    begin
      state_q  <= state_d;
      tmr_q    <= tmr_d;
      cnt_q    <= cnt_d;
      pend_v_q <= pend_v_d;
      if (pend_set)
        pend_q <= REQ_CMD_IN;
      if (launch)
        cmd_q  <= src;
    end
  end

  // ----------------------------------------------------------------
  // Display buffers and setup results
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      xb_q         <= 9'h000;
      yb_q         <= 9'h000;
      pat_q        <= 12'h000;
      op_char_q    <= 1'b0;
      half_q       <= 1'b0;
      CHAN_OUT     <= 1'b0;
      AC_RES_OUT   <= 12'h000;
      IDX_RES_OUT  <= 12'h000;
      XLOC_RES_OUT <= 12'h000;
    end
    else if (setup_end)
    begin
      op_char_q    <= cmd_q.is_char;
      half_q       <= half_w;
      pat_q        <= cmd_q.pat;                                 // see [RULE14] [RULE20]
      xb_q         <= cmd_q.is_char ? xloc_nw[8:0] : idx_eff[8:0];  // see [RULE8] [RULE16]
      yb_q         <= cmd_q.is_char ? yc_base : cmd_q.ac[8:0];   // see [RULE8]
      CHAN_OUT     <= cmd_q.is_char ? CHAN_OUT : idx_eff[11];    // see [RULE9]
      AC_RES_OUT   <= cmd_q.is_char ? ac_chr : cmd_q.ac;
      IDX_RES_OUT  <= cmd_q.is_char ? cmd_q.idx : idx_eff;       // see [RULE10]
      XLOC_RES_OUT <= cmd_q.is_char ? xloc_nw : cmd_q.xloc;
    end
  end

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      X_OUT      <= 9'h000;
      Y_OUT      <= 9'h000;
      INTENS_OUT <= 1'b0;
      DONE_OUT   <= 1'b0;
      STALL_OUT  <= 1'b0;
      BUSY_OUT   <= 1'b0;
    end
    else
    begin
      if (jam)
      begin
        X_OUT <= jam_xy[17:9];                                   // see [RULE19]
        Y_OUT <= jam_xy[8:0];                                    // see [RULE19]
      end
      INTENS_OUT <= lit_d;
      DONE_OUT   <= setup_end;
      STALL_OUT  <= (state_d == pcd_pkg::S_SETUP) || pend_v_d;   // see [RULE1] [RULE17]
      BUSY_OUT   <= (state_d != pcd_pkg::S_IDLE) || pend_v_d;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  wire logic [11:0] rd_mux =
      (REG_ADDR_IN == pcd_pkg::REG_CTRL)   ? {11'h000, size_q} :
      (REG_ADDR_IN == pcd_pkg::REG_STATUS) ? {9'h000, pend_v_q, STALL_OUT, BUSY_OUT} :
      (REG_ADDR_IN == pcd_pkg::REG_XPOS)   ? {3'h0, X_OUT} :
      (REG_ADDR_IN == pcd_pkg::REG_YPOS)   ? {3'h0, Y_OUT} : 12'h000;

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      size_q        <= pcd_pkg::SIZE_RESET;
      REG_RDATA_OUT <= 12'h000;
    end
    else
    begin
      if (REG_WR_IN && REG_ADDR_IN == pcd_pkg::REG_CTRL)
        size_q <= REG_WDATA_IN[pcd_pkg::CTRL_SIZE];
      REG_RDATA_OUT <= REG_RD_IN ? rd_mux : 12'h000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] ph_cnt_q;
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
      ph_cnt_q <= 16'h0000;
    else
      ph_cnt_q <= (state_d != state_q) ? 16'h0000 : ph_cnt_q + 16'h0001;
  end

  a_setup_len: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // see [RULE17]
    setup_end |-> ph_cnt_q + 16'h0001 == (!cmd_q.is_char ? pcd_pkg::PT_SETUP_CYC
      : cmd_q.short_setup ? pcd_pkg::CHR_SETUP_S_CYC : pcd_pkg::CHR_SETUP_L_CYC))
    else $error("setup length wrong");
  a_settle_len: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // see [RULE6]
    (state_q == pcd_pkg::S_SETTLE && state_d != pcd_pkg::S_SETTLE)
      |-> ph_cnt_q + 16'h0001 == pcd_pkg::SETTLE_CYC)
    else $error("settle length wrong");
  a_lit_dwell: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // see [RULE6]
    (jam && op_char_q) |=> INTENS_OUT[*8] ##292 (INTENS_OUT && tmr_q == 16'h0001))
    else $error("lit dwell not 3 us");
  a_index_inc: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // see [RULE10]
    (setup_end && !cmd_q.is_char && cmd_q.indirect) |=> IDX_RES_OUT[9:0]
      == $past(cmd_q.idx[9:0]) + 10'h001 && IDX_RES_OUT[11:10] == $past(cmd_q.idx[11:10]))
    else $error("index increment wrong");
  a_chan_pick: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // see [RULE9]
    (setup_end && !cmd_q.is_char) |=> CHAN_OUT == $past(cmd_q.idx[11])
      && xb_q == IDX_RES_OUT[8:0] && yb_q == $past(cmd_q.ac[8:0]))
    else $error("point channel or column wrong");
  a_col_step: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // see [RULE16]
    (setup_end && cmd_q.is_char) |=> XLOC_RES_OUT == $past(cmd_q.xloc)
      + ($past(half_w) ? pcd_pkg::HALF_XINC : pcd_pkg::FULL_XINC) && xb_q == XLOC_RES_OUT[8:0])
    else $error("column step wrong");
  a_row_force: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // see [RULE15]
    (setup_end && cmd_q.is_char && !half_w) |=> AC_RES_OUT[4:0] == pcd_pkg::FULL_ACLOW
      && yb_q[4:0] == 5'h00 && yb_q[8:5] == $past(cmd_q.ac[8:5]))
    else $error("full size row setup wrong");
  a_beam_hold: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // see [RULE7]
    !jam |=> $stable(X_OUT) && $stable(Y_OUT))
    else $error("beam moved without a lit point");
  a_stall_pend: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // see [RULE1]
    pend_set |=> STALL_OUT throughout (pend_v_q [*1]))
    else $error("no stall while request pending");

endmodule : pcd_ctrl

// ==== pcd_cpu_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Processor side: one display instruction in flight at a time
// ----------------------------------------------------------------
module pcd_cpu_model
(
  input  wire logic              clk_in,        // System clock
  input  wire logic              rst_in,        // Async reset, active high
  input  wire logic              go_in,         // Execute cmd_in when free
  input  wire pcd_pkg::pcd_cmd_t cmd_in,        // Instruction operands
  input  wire logic              stall_in,      // Controller holds processor
  input  wire logic              done_in,       // Setup results valid
  input  wire logic [11:0]       xres_in,       // New column word
  output pcd_pkg::pcd_cmd_t      req_cmd_out,   // Request operands
  output logic                   req_valid_out, // Request strobe
  output logic [11:0]            loc1_out       // Column word in memory
);
  logic              want_q;
  logic              wait_q;
  pcd_pkg::pcd_cmd_t cmd_q;
  // Operands leave with the column word as memory holds it at issue time
  wire pcd_pkg::pcd_cmd_t issue_cmd = {cmd_q.is_char, cmd_q.short_setup, cmd_q.indirect,
                                       cmd_q.ac, cmd_q.idx, cmd_q.pat, loc1_out};

  always @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      want_q        <= 1'b0;
      wait_q        <= 1'b0;
      cmd_q         <= '0;
      req_valid_out <= 1'b0;
      req_cmd_out   <= '0;
      loc1_out      <= 12'h000;
    end
    else
    begin
      req_valid_out <= 1'b0;
      // Released operands flip so a stale value is never mistaken for live
      if (req_valid_out)
        req_cmd_out <= ~req_cmd_out;
      if (go_in)
      begin
        want_q <= 1'b1;
        cmd_q  <= go_in ? cmd_in : cmd_q;
      end
      if (done_in)
      begin
        wait_q <= 1'b0;
        if (cmd_q.is_char)
          loc1_out <= xres_in;
      end
      else if (want_q && !wait_q && !stall_in)
      begin
        req_valid_out <= 1'b1;
        req_cmd_out   <= issue_cmd;
        want_q        <= 1'b0;
        wait_q        <= 1'b1;
      end
    end
endmodule : pcd_cpu_model

// ==== pcd_ctrl_test.sv ====
`timescale 1ns/100ps
module pcd_ctrl_test;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              go = 1'b0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [3:0]        raddr = 4'h0;
  logic [11:0]       wdata = 12'h000;
  pcd_pkg::pcd_cmd_t cmd = '0;
  pcd_pkg::pcd_cmd_t req_cmd;
  logic              req_valid, stall, done, intens, chan, busy, e_chan;
  logic [11:0]       ac_res, idx_res, xloc_res, loc1, rdata, rd_val;
  logic [11:0]       e_loc = 12'h000;
  logic [8:0]        x, y, last_x, last_y;
  logic [8:0]        q_x[$];
  logic [8:0]        q_y[$];
  integer            q_m[$];
  integer            t_end, k;
  integer            seed = 32'h9125abd3;
  integer            n_fail = 0;
  integer            check_count = 0;
  pcd_pkg::pcd_cmd_t c;

  always #5 clk = ~clk;

  pcd_cpu_model i_cpu (.clk_in(clk), .rst_in(rst), .go_in(go), .cmd_in(cmd), .stall_in(stall),
    .done_in(done), .xres_in(xloc_res), .req_cmd_out(req_cmd), .req_valid_out(req_valid),
    .loc1_out(loc1));

  pcd_ctrl i_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .REQ_VALID_IN(req_valid), .REQ_CMD_IN(req_cmd),
    .STALL_OUT(stall), .DONE_OUT(done), .AC_RES_OUT(ac_res), .IDX_RES_OUT(idx_res),
    .XLOC_RES_OUT(xloc_res), .X_OUT(x), .Y_OUT(y), .INTENS_OUT(intens), .CHAN_OUT(chan),
    .BUSY_OUT(busy), .REG_ADDR_IN(raddr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_RDATA_OUT(rdata));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge clk);
    raddr <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    raddr <= a;
    rd    <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    #1;
    rd_val = rdata;
  endtask : reg_rd

  // Issue one instruction, check setup timing and results, queue the lit points
  task automatic run(input pcd_pkg::pcd_cmd_t cc, input logic half, input logic lat);
    integer      n, m, i, nexp, st;
    logic [11:0] xn, idx_e;
    logic [8:0]  yb;
    n = 0;
    st = half ? 2 : 4;
    nexp = !cc.is_char ? 320 : (cc.short_setup ? 480 : 640);
    @(posedge clk);
    cmd <= cc;
    go  <= 1'b1;
    @(posedge clk);
    go  <= 1'b0;
    #1;
    while (req_valid !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    n = 0;
    while (done !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n == 3)
        chk(stall, 1'b1);
    end
    if (lat)
      chk(12'(n), 12'(nexp));
    else
      chk(12'(n >= 1796 + nexp), 12'h001);
    q_m.delete();
    q_x.delete();
    q_y.delete();
    // Settling spans the 1500 cycles after the setup-done edge
    m = 1500;
    if (cc.is_char)
    begin
      xn = e_loc + (half ? 12'h004 : 12'h008);
      yb = half ? {cc.ac[8:4], 4'h0} : {cc.ac[8:5], 5'h00};
      chk(ac_res, half ? {cc.ac[11:4], 4'hc} : {cc.ac[11:5], 5'h18});
      chk(xloc_res, xn);
      e_loc = xn;
      for (i = 0; i < 12; i++)
        if (cc.pat[11 - i])
        begin
          q_m.push_back(m);
          q_x.push_back(9'(xn[8:0] + (i > 5 ? st : 0)));
          q_y.push_back(9'(yb + (i % 6) * st));
          t_end = m + 300;
          m += 300;
        end
        else
          m += 100;
    end
    else
    begin
      idx_e = cc.indirect ? {cc.idx[11:10], cc.idx[9:0] + 10'h001} : cc.idx;
      chk(idx_res, idx_e);
      chk(ac_res, cc.ac);
      e_chan = idx_e[11];
      q_m.push_back(m);
      q_x.push_back(idx_e[8:0]);
      q_y.push_back(cc.ac[8:0]);
      t_end = m + 100;
    end
  endtask : run

  // Follow the scan from the setup-done cycle, cycle by cycle
  task automatic scan(input logic pt);
    integer m;
    for (m = 1; m <= t_end; m++)
    begin
      @(posedge clk);
      #1;
      if (m == 1499)
        chk(intens, 1'b0);
      if (q_m.size() > 0 && q_m[0] == m)
      begin
        last_x = q_x[0];
        last_y = q_y[0];
        chk(x, q_x.pop_front());
        chk(y, q_y.pop_front());
        chk(intens, 1'b1);
        if (pt)
          chk(chan, e_chan);
        void'(q_m.pop_front());
      end
    end
    chk(intens, 1'b0);
    chk(busy, 1'b0);
    reg_rd(4'h2);
    chk(rd_val, {3'h0, last_x});
    reg_rd(4'h3);
    chk(rd_val, {3'h0, last_y});
  endtask : scan

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    // Longest legal run is about 50k cycles
    #800000;
    n_fail++;
    summarize();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    reg_rd(4'h0);
    chk(rd_val, 12'h001);
    reg_rd(4'h1);
    chk(rd_val, 12'h000);
    reg_rd(4'h7);
    chk(rd_val, 12'h000);
    reg_wr(4'h2, 12'hfff);
    reg_rd(4'h2);
    chk(rd_val, 12'h000);
    $display("test registers done");
    for (k = 0; k < 3; k++)
    begin
      c = '0;
      c.ac = 12'($random(seed));
      c.idx = 12'($random(seed));
      c.indirect = (k != 0);
      if (k == 2)
        c.idx[9:0] = 10'h3ff;
      run(c, 1'b0, 1'b1);
      scan(1'b1);
    end
    $display("test points done");
    for (k = 0; k < 6; k++)
    begin
      if (k == 4)
      begin
        reg_wr(4'h0, 12'h000);
        reg_rd(4'h0);
        chk(rd_val, 12'h000);
      end
      c = '0;
      c.is_char = 1'b1;
      c.short_setup = k[0];
      c.ac = 12'($random(seed));
      c.pat = (k == 0) ? 12'h800 : 12'($random(seed)) | 12'h001;
      run(c, k >= 4, 1'b1);
      scan(1'b0);
    end
    reg_wr(4'h0, 12'h001);
    $display("test characters done");
    c.pat = 12'h800;
    c.short_setup = 1'b0;
    run(c, 1'b0, 1'b1);
    c.ac = 12'($random(seed));
    c.pat = 12'h021;
    run(c, 1'b0, 1'b0);
    scan(1'b0);
    $display("test stall done");
    summarize();
  end
endmodule : pcd_ctrl_test
